// ===== src/arbc_pkg.sv
// Shared constants and types for the record-path ADC back end
`default_nettype none
package arbc_pkg;
  // Register addresses
  localparam logic [6:0] ADDR_ADC_CTRL = 7'h60;
  localparam logic [6:0] ADDR_PGA_L = 7'h61;
  localparam logic [6:0] ADDR_PGA_R = 7'h62;
  localparam logic [6:0] ADDR_VOL_L = 7'h63;
  localparam logic [6:0] ADDR_VOL_R = 7'h64;
  localparam logic [6:0] ADDR_PEAK_L = 7'h65;
  localparam logic [6:0] ADDR_PEAK_R = 7'h66;
  localparam logic [6:0] ADDR_ALC1 = 7'h67;
  localparam logic [6:0] ADDR_ALC2 = 7'h68;
  localparam logic [6:0] ADDR_ALC3 = 7'h69;
  localparam logic [6:0] ADDR_STATUS = 7'h6A;
  localparam logic [6:0] ADDR_GAIN_L = 7'h6B;
  localparam logic [6:0] ADDR_GAIN_R = 7'h6C;
  localparam logic [6:0] ADDR_CLK_SEL = 7'h76;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Field positions
  localparam int QUARTER_BIT = 0;
  localparam int ROUTE_LSB = 1;
  localparam int SRC_LSB = 2;
  localparam int ALC_EN_BIT = 0;
  localparam int ALC_MODE_BIT = 1;
  localparam int REC_LSB = 2;
  localparam int EXC_LSB = 4;
  localparam logic [1:0] REC_NONE = 2'h0;
  localparam logic [1:0] REC_NORMAL = 2'h1;
  // Datapath sizes and counts
  localparam int THERM_W = 31;
  localparam int CIC_W = 26;
  localparam int SINC_ORDER = 5;
  localparam int SINC_RATIO_HALF = 16;
  localparam int SINC_RATIO_QUARTER = 8;
  localparam int NORM_SHIFT = 5;
  localparam logic [5:0] THERM_MID = 6'h10;
  localparam int SMP_W = 24;
  localparam int HB_ACC_W = SMP_W + 6;
  localparam int HB_CENTER_SHIFT = 4;
  localparam logic signed [HB_ACC_W-1:0] HB_SIDE = 30'sh9;
  localparam int HB_NORM = 5;
  localparam logic [8:0] VOL_FULL = 9'h100;
  localparam logic [5:0] PGA_MAX_CODE = 6'h30;
  localparam int TIMER_SHIFT = 4;
  localparam real MOD_MAX_MHZ = 6.144;
  typedef enum logic [2:0] {
    ALC_WATCH = 3'b001,
    ALC_ATTACK = 3'b010,
    ALC_HOLD = 3'b100
  } arbc_alc_t;
endpackage
`default_nettype wire

// ===== src/arbc_sinc5.sv
// Thermometer decode and fifth-order sinc decimator for one channel
`default_nettype none
module arbc_sinc5 #(
  parameter int THERM_W = arbc_pkg::THERM_W,
  parameter int CW = arbc_pkg::CIC_W
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic mod_tick,
  input wire logic quarter,
  input wire logic [THERM_W-1:0] therm,
  output logic out_valid,
  output logic [CW-1:0] out_data
);
  import arbc_pkg::*;
  typedef struct packed {
    logic [SINC_ORDER-1:0][CW-1:0] integ;
    logic [SINC_ORDER-1:0][CW-1:0] dly;
    logic [3:0] ph;
    logic vld;
    logic [CW-1:0] dat;
  } arbc_sinc_st_t;
  arbc_sinc_st_t st_reg, st_next;

  always_comb begin
    logic [5:0] bin;
    logic [CW-1:0] x;
    logic [CW-1:0] d;
    logic [CW-1:0] c;
    bin = 6'($countones(therm)); // [RULE_03]
    x = CW'($signed(bin - THERM_MID));
    d = '0;
    c = '0;
    st_next = st_reg;
    st_next.vld = 1'b0;
    if (mod_tick) begin
      st_next.integ[0] = st_reg.integ[0] + x;
      for (int k = 1; k < SINC_ORDER; k++) begin
        st_next.integ[k] = st_reg.integ[k] + st_reg.integ[k-1];
      end
      st_next.ph = st_reg.ph + 4'h1;
      if (st_reg.ph == 4'(quarter ? SINC_RATIO_QUARTER - 1 : SINC_RATIO_HALF - 1)) begin
        st_next.ph = 4'h0;
        d = st_reg.integ[SINC_ORDER-1];
        for (int k = 0; k < SINC_ORDER; k++) begin
          c = d - st_reg.dly[k];
          st_next.dly[k] = d;
          d = c;
        end
        st_next.vld = 1'b1;
        st_next.dat = quarter ? d << NORM_SHIFT : d;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign out_valid = st_reg.vld;
  assign out_data = st_reg.dat;
endmodule
`default_nettype wire

// ===== src/arbc_buf2.sv
// Two-entry sample buffer with valid and ready on both sides
`default_nettype none
module arbc_buf2 #(
  parameter int W = 48
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } arbc_buf_st_t;
  arbc_buf_st_t st_reg, st_next;

  assign in_ready = st_reg.cnt != 2'h2;
  assign out_valid = st_reg.cnt != 2'h0;
  assign out_data = st_reg.mem[st_reg.rp];

  always_comb begin
    logic push;
    logic pop;
    push = in_valid && in_ready && clk_en;
    pop = out_valid && out_ready && clk_en;
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = ~st_reg.wp;
    end
    if (pop) begin
      st_next.rp = ~st_reg.rp;
    end
    st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

// ===== src/arbc_top.sv
// Record-path ADC back end: clocking, decimation, volume, peaks and level control
//
// How it works
// [RULE_01] Modulator clock is half or a quarter of the ADC master clock.
// [RULE_02] Sinc5 decimates by 16 or 8, then three half-band stages by two.
// [RULE_03] Thermometer flash output is counted into a 6-bit binary word.
// [RULE_04] Output samples are 24-bit two's complement, routed to selected destinations.
// [RULE_05] Clock select register picks the ADC master clock source.
// [RULE_06] Each channel has a 256-step linear volume, one step is 1/256.
// [RULE_07] Each channel keeps a peak level register cleared by reading it.
// [RULE_08] Master clock divider divides by one, two or three.
// [RULE_09] Software should set the output port clock divider to the same ratio.
// [RULE_10] Quarter select divides the modulator clock by four to stay in range.
// [RULE_11] PGA gain code spans 0 to 24 dB in half-dB steps.
// [RULE_12] Attack threshold exceeded lowers both gains by one step.
// [RULE_13] Attack waits the attack interval, resamples, steps again while above.
// [RULE_14] One common offset from the initial gains; gains never exceed initial values.
// [RULE_15] Limit mode one needs both channels above threshold, zero needs either.
// [RULE_16] No recovery keeps the reduction until enable toggles or third register written.
// [RULE_17] Normal recovery raises gain one step per quiet recovery interval.
// [RULE_18] Recovery holds while output exceeds the recovery threshold.
// [RULE_19] Fully restored gain stays until attack starts again.
// [RULE_20] Limited recovery counts noisy intervals and stops at the count limit.
// [RULE_21] Attack during limited recovery re-enters attack and clears the counter.
// [RULE_22] Gain offset saturates at the lowest PGA code, never wraps.
`default_nettype none
module arbc_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [3:0] mclk_src_en,
  input wire logic [arbc_pkg::THERM_W-1:0] mod_therm_l,
  input wire logic [arbc_pkg::THERM_W-1:0] mod_therm_r,
  output logic mod_sample,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [5:0] pga_gain_l,
  output logic [5:0] pga_gain_r,
  output logic out_valid,
  input wire logic out_ready,
  output logic [arbc_pkg::SMP_W-1:0] out_data_l,
  output logic [arbc_pkg::SMP_W-1:0] out_data_r,
  output logic [2:0] out_route
);
  import arbc_pkg::*;

  typedef struct packed {
    logic [7:0] adc_ctrl;
    logic [1:0][7:0] pga_init;
    logic [1:0][7:0] vol;
    logic [7:0] alc1;
    logic [7:0] alc2;
    logic [7:0] alc3;
    logic [7:0] clk_sel;
    logic [1:0][7:0] peak;
    logic [7:0] rdata;
    logic [1:0] div_cnt;
    logic [1:0] mod_cnt;
    logic mod_tick;
    logic [1:0][2:0][6:0][SMP_W-1:0] hb;
    logic [2:0] hb_ph;
    logic [1:0][2:0][SMP_W-1:0] hb_out;
    logic [2:0] hb_vld;
    logic [1:0][SMP_W-1:0] smp;
    logic smp_vld;
    logic ovr;
    arbc_alc_t alc_st;
    logic [5:0] off;
    logic [8:0] tmr;
    logic [8:0] rtmr;
    logic rexc;
    logic [3:0] ecnt;
    logic [1:0][5:0] gain;
  } arbc_st_t;

  arbc_st_t st_reg, st_next;
  logic [1:0] sinc_vld;
  logic [1:0][CIC_W-1:0] sinc_dat;
  logic buf_in_ready;
  logic [2*SMP_W-1:0] buf_dat;

  // Half-band tap set -1 0 9 16 9 0 -1, scaled by 1/32, saturated
  function automatic logic [SMP_W-1:0] hb_filt(input logic [6:0][SMP_W-1:0] t);
    logic signed [HB_ACC_W-1:0] acc;
    logic signed [HB_ACC_W-1:0] y;
    acc = (HB_ACC_W'($signed(t[3])) <<< HB_CENTER_SHIFT)
        + HB_SIDE * (HB_ACC_W'($signed(t[2])) + HB_ACC_W'($signed(t[4])))
        - (HB_ACC_W'($signed(t[0])) + HB_ACC_W'($signed(t[6])));
    y = acc >>> HB_NORM;
    if (y[HB_ACC_W-1] && !(&y[HB_ACC_W-2:SMP_W-1])) begin
      hb_filt = {1'b1, {(SMP_W-1){1'b0}}};
    end else if (!y[HB_ACC_W-1] && (|y[HB_ACC_W-2:SMP_W-1])) begin
      hb_filt = {1'b0, {(SMP_W-1){1'b1}}};
    end else begin
      hb_filt = y[SMP_W-1:0];
    end
  endfunction

  // Eight-bit magnitude of a sample
  function automatic logic [7:0] lvl8(input logic [SMP_W-1:0] v);
    logic [SMP_W-1:0] mag;
    mag = v[SMP_W-1] ? SMP_W'(-v) : v;
    lvl8 = mag[SMP_W-1] ? 8'hFF : mag[SMP_W-2:SMP_W-9];
  endfunction

  // Sinc decimators, one per channel
  for (genvar c = 0; c < 2; c++) begin : g_ch
    arbc_sinc5 #(
      .THERM_W(THERM_W),
      .CW(CIC_W)
    ) u_sinc (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .mod_tick(st_reg.mod_tick),
      .quarter(st_reg.adc_ctrl[QUARTER_BIT]),
      .therm(c == 0 ? mod_therm_l : mod_therm_r),
      .out_valid(sinc_vld[c]),
      .out_data(sinc_dat[c])
    );
  end

  // Sample buffer towards the output destinations
  arbc_buf2 #(
    .W(2 * SMP_W)
  ) u_buf (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .in_valid(st_reg.smp_vld),
    .in_ready(buf_in_ready),
    .in_data({st_reg.smp[0], st_reg.smp[1]}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(buf_dat)
  );

  always_comb begin
    logic sel_tick;
    logic adc_tick;
    logic quarter;
    logic [1:0] div_max;
    logic hb_in_v;
    logic [SMP_W-1:0] hb_in;
    logic s_vld;
    logic [1:0][7:0] lvl;
    logic [1:0] ex_a;
    logic [1:0] ex_r;
    logic hit_a;
    logic hit_r;
    logic noisy;
    logic do_step;
    logic [1:0] rmode;
    logic [8:0] atk_int;
    logic [8:0] rec_int;
    logic [5:0] init;
    logic signed [SMP_W+10:0] prod;
    sel_tick = 1'b0;
    adc_tick = 1'b0;
    quarter = st_reg.adc_ctrl[QUARTER_BIT];
    div_max = 2'h0;
    hb_in_v = 1'b0;
    hb_in = '0;
    s_vld = st_reg.hb_vld[2];
    lvl = '0;
    ex_a = '0;
    ex_r = '0;
    hit_a = 1'b0;
    hit_r = 1'b0;
    do_step = 1'b0;
    noisy = 1'b0;
    rmode = st_reg.alc1[REC_LSB+:2];
    atk_int = 9'({1'b0, st_reg.alc2[3:0]} + 5'h01) << TIMER_SHIFT;
    rec_int = 9'({1'b0, st_reg.alc3[3:0]} + 5'h01) << TIMER_SHIFT;
    init = 6'h00;
    prod = '0;
    st_next = st_reg;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_ADC_CTRL: st_next.adc_ctrl = reg_wdata;
        ADDR_PGA_L: st_next.pga_init[0] = reg_wdata;
        ADDR_PGA_R: st_next.pga_init[1] = reg_wdata;
        ADDR_VOL_L: st_next.vol[0] = reg_wdata;
        ADDR_VOL_R: st_next.vol[1] = reg_wdata;
        ADDR_ALC1: st_next.alc1 = reg_wdata;
        ADDR_ALC2: st_next.alc2 = reg_wdata;
        ADDR_ALC3: st_next.alc3 = reg_wdata;
        ADDR_CLK_SEL: st_next.clk_sel = reg_wdata;
        default: ;
      endcase
    end

    // Register reads, answer one cycle later
    if (reg_rd) begin
      case (reg_addr)
        ADDR_ADC_CTRL: st_next.rdata = st_reg.adc_ctrl;
        ADDR_PGA_L: st_next.rdata = st_reg.pga_init[0];
        ADDR_PGA_R: st_next.rdata = st_reg.pga_init[1];
        ADDR_VOL_L: st_next.rdata = st_reg.vol[0];
        ADDR_VOL_R: st_next.rdata = st_reg.vol[1];
        ADDR_PEAK_L: st_next.rdata = st_reg.peak[0];
        ADDR_PEAK_R: st_next.rdata = st_reg.peak[1];
        ADDR_ALC1: st_next.rdata = st_reg.alc1;
        ADDR_ALC2: st_next.rdata = st_reg.alc2;
        ADDR_ALC3: st_next.rdata = st_reg.alc3;
        ADDR_STATUS: st_next.rdata = {5'h00, st_reg.ovr, st_reg.alc_st == ALC_HOLD, st_reg.alc_st == ALC_ATTACK};
        ADDR_GAIN_L: st_next.rdata = {2'h0, st_reg.gain[0]};
        ADDR_GAIN_R: st_next.rdata = {2'h0, st_reg.gain[1]};
        ADDR_CLK_SEL: st_next.rdata = st_reg.clk_sel;
        default: st_next.rdata = REG_RESET;
      endcase
    end

    // Master clock source, divider and modulator clock
    sel_tick = mclk_src_en[st_reg.clk_sel[SRC_LSB+:2]]; // [RULE_05]
    case (st_reg.clk_sel[1:0])
      2'h0: div_max = 2'h0;
      2'h1: div_max = 2'h1;
      default: div_max = 2'h2;
    endcase
    adc_tick = sel_tick && st_reg.div_cnt >= div_max; // [RULE_08]
    if (sel_tick) begin
      st_next.div_cnt = adc_tick ? 2'h0 : st_reg.div_cnt + 2'h1;
    end
    st_next.mod_tick = adc_tick && st_reg.mod_cnt >= (quarter ? 2'h3 : 2'h1); // [RULE_01] [RULE_10]
    if (adc_tick) begin
      st_next.mod_cnt = st_next.mod_tick ? 2'h0 : st_reg.mod_cnt + 2'h1;
    end

    // Three half-band stages, each halving the rate
    st_next.hb_vld = 3'h0;
    for (int s = 0; s < 3; s++) begin
      hb_in_v = (s == 0) ? &sinc_vld : st_reg.hb_vld[(s == 0) ? 0 : s - 1];
      if (hb_in_v) begin
        st_next.hb_ph[s] = ~st_reg.hb_ph[s];
        st_next.hb_vld[s] = st_reg.hb_ph[s]; // [RULE_02]
        for (int c = 0; c < 2; c++) begin
          hb_in = (s == 0) ? sinc_dat[c][CIC_W-1:CIC_W-SMP_W] : st_reg.hb_out[c][(s == 0) ? 0 : s - 1];
          st_next.hb[c][s] = {st_reg.hb[c][s][5:0], hb_in};
          if (st_reg.hb_ph[s]) begin
            st_next.hb_out[c][s] = hb_filt(st_next.hb[c][s]);
          end
        end
      end
    end

    // Peak detectors, a new peak beats the read clear
    for (int c = 0; c < 2; c++) begin
      lvl[c] = lvl8(st_reg.hb_out[c][2]);
      if (reg_rd && reg_addr == (c == 0 ? ADDR_PEAK_L : ADDR_PEAK_R)) begin
        st_next.peak[c] = 8'h00; // [RULE_07]
      end
      if (s_vld && lvl[c] > st_next.peak[c]) begin
        st_next.peak[c] = lvl[c]; // [RULE_07]
      end
    end

    // Volume stage holding one sample for the buffer
    if (reg_rd && reg_addr == ADDR_STATUS) begin
      st_next.ovr = 1'b0;
    end
    if (buf_in_ready) begin
      st_next.smp_vld = 1'b0;
    end
    if (s_vld) begin
      if (st_reg.smp_vld && !buf_in_ready) begin
        st_next.ovr = 1'b1;
      end
      for (int c = 0; c < 2; c++) begin
        prod = $signed(st_reg.hb_out[c][2]) * $signed({2'h0, VOL_FULL - {1'b0, st_reg.vol[c]}}); // [RULE_06]
        st_next.smp[c] = prod[SMP_W+7:8]; // [RULE_04]
      end
      st_next.smp_vld = 1'b1;
    end

    // Level control
    for (int c = 0; c < 2; c++) begin
      ex_a[c] = lvl[c] > {st_reg.alc2[7:4], 4'hF};
      ex_r[c] = lvl[c] > {st_reg.alc3[7:4], 4'hF};
    end
    hit_a = st_reg.alc1[ALC_MODE_BIT] ? &ex_a : |ex_a; // [RULE_15]
    hit_r = |ex_r;
    noisy = st_reg.rexc | hit_r;
    if (s_vld) begin
      case (st_reg.alc_st)
        ALC_WATCH: begin
          if (hit_a) begin
            do_step = 1'b1; // [RULE_12] [RULE_19]
          end else if (rmode != REC_NONE) begin // [RULE_16]
            st_next.rexc = noisy; // [RULE_18]
            if (st_reg.rtmr > 9'h001) begin
              st_next.rtmr = st_reg.rtmr - 9'h001;
            end else begin
              st_next.rtmr = rec_int;
              st_next.rexc = 1'b0;
              if (rmode == REC_NORMAL) begin
                if (!noisy && st_reg.off != 6'h00) begin
                  st_next.off = st_reg.off - 6'h01; // [RULE_17]
                end
              end else if (noisy) begin
                st_next.ecnt = st_reg.ecnt + 4'h1; // [RULE_20]
                if (st_next.ecnt >= st_reg.alc1[EXC_LSB+:4]) begin
                  st_next.alc_st = ALC_HOLD; // [RULE_20]
                end
              end else if (st_reg.off != 6'h00) begin
                st_next.off = st_reg.off - 6'h01;
              end
            end
          end
        end
        ALC_ATTACK: begin
          if (st_reg.tmr > 9'h001) begin
            st_next.tmr = st_reg.tmr - 9'h001;
          end else if (hit_a) begin
            do_step = 1'b1; // [RULE_13]
          end else begin
            st_next.alc_st = ALC_WATCH;
            st_next.rtmr = rec_int;
            st_next.rexc = 1'b0;
          end
        end
        ALC_HOLD: begin
          do_step = hit_a; // [RULE_21]
        end
        default: st_next.alc_st = ALC_WATCH;
      endcase
    end
    if (do_step) begin
      st_next.off = (st_reg.off == PGA_MAX_CODE) ? st_reg.off : st_reg.off + 6'h01; // [RULE_22]
      st_next.tmr = atk_int; // [RULE_13]
      st_next.alc_st = ALC_ATTACK;
      st_next.ecnt = 4'h0; // [RULE_21]
    end
    if (!st_reg.alc1[ALC_EN_BIT] || (reg_wr && reg_addr == ADDR_ALC3)) begin
      st_next.off = 6'h00; // [RULE_16]
      st_next.alc_st = ALC_WATCH;
      st_next.tmr = 9'h000;
      st_next.rtmr = rec_int;
      st_next.rexc = 1'b0;
      st_next.ecnt = 4'h0;
    end

    // Gains follow the initial values less the common offset
    for (int c = 0; c < 2; c++) begin
      init = (st_reg.pga_init[c][5:0] > PGA_MAX_CODE) ? PGA_MAX_CODE : st_reg.pga_init[c][5:0]; // [RULE_11]
      st_next.gain[c] = (init > st_reg.off) ? init - st_reg.off : 6'h00; // [RULE_14]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.alc_st <= ALC_WATCH;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign mod_sample = st_reg.mod_tick;
  assign reg_rdata = st_reg.rdata;
  assign pga_gain_l = st_reg.gain[0];
  assign pga_gain_r = st_reg.gain[1];
  assign out_data_l = buf_dat[2*SMP_W-1:SMP_W];
  assign out_data_r = buf_dat[SMP_W-1:0];
  assign out_route = st_reg.adc_ctrl[ROUTE_LSB+:3]; // [RULE_04]
endmodule
`default_nettype wire

// ===== testbench/arbc_top_properties.sv
// Port checks for the record back end
`default_nettype none
module arbc_top_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic mod_sample,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [5:0] pga_gain_l,
  input wire logic [5:0] pga_gain_r,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [arbc_pkg::SMP_W-1:0] out_data_l,
  input wire logic [2:0] out_route
);
  timeunit 1ns;
  timeprecision 1ps;
  import arbc_pkg::*;
  logic [1:0] quiet_reg;
  logic [1:0] quiet_next;
  logic [2:0] route_w;
  logic [5:0] init_l_reg;
  assign route_w = reg_wdata[3:1];
  // Left initial gain as last written, clamped to the top code
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      init_l_reg <= 6'h00;
    end else if (clk_en && reg_wr && reg_addr == ADDR_PGA_L) begin
      init_l_reg <= (reg_wdata[5:0] > PGA_MAX_CODE) ? PGA_MAX_CODE : reg_wdata[5:0];
    end
  end
  always_comb begin
    quiet_next = quiet_reg;
    if (reg_wr) begin
      quiet_next = 2'h0;
    end else if (quiet_reg != 2'h3) begin
      quiet_next = quiet_reg + 2'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      quiet_reg <= 2'h0;
    end else begin
      quiet_reg <= quiet_next;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence ctrl_wr_s;
    clk_en && reg_wr && reg_addr == ADDR_ADC_CTRL;
  endsequence
  sequence alc_reset_s;
    clk_en && reg_wr && reg_addr == ADDR_ALC3;
  endsequence
  sequence gain_fall_s;
    quiet_reg == 2'h3 && pga_gain_l < $past(pga_gain_l) && $past(pga_gain_r) != 6'h00;
  endsequence
  route_update_a: assert property (ctrl_wr_s |=> out_route == $past(route_w))
    else $error("route does not follow control write");
  unmapped_read_a: assert property (clk_en && reg_rd && reg_addr == 7'h7F |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!(clk_en && reg_rd) |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  mod_pulse_a: assert property (mod_sample && clk_en |=> !mod_sample)
    else $error("modulator tick longer than one cycle");
  gain_range_a: assert property (pga_gain_l <= PGA_MAX_CODE && pga_gain_r <= PGA_MAX_CODE)
    else $error("gain code out of range");
  gain_step_a: assert property (quiet_reg == 2'h3 && pga_gain_l != $past(pga_gain_l)
    |-> pga_gain_l + 6'h01 == $past(pga_gain_l) || pga_gain_l == $past(pga_gain_l) + 6'h01)
    else $error("gain moved by more than one step");
  gains_together_a: assert property (gain_fall_s |-> pga_gain_r < $past(pga_gain_r))
    else $error("gains not lowered together");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data_l))
    else $error("stalled sample not held");
  alc_reset_a: assert property (alc_reset_s |-> ##2 pga_gain_l == init_l_reg)
    else $error("level control reset did not restore gain");
endmodule
bind arbc_top arbc_top_checker chk (.clk_sys, .sys_rst, .clk_en, .mod_sample, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .pga_gain_l, .pga_gain_r, .out_valid, .out_ready, .out_data_l, .out_route);
`default_nettype wire

// ===== testbench/arbc_sink.sv
// Receiver model for the output sample stream
`default_nettype none
module arbc_sink (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic out_valid,
  input wire logic [arbc_pkg::SMP_W-1:0] out_data_l,
  input wire logic [arbc_pkg::SMP_W-1:0] out_data_r,
  output logic out_ready,
  output logic [15:0] taken,
  output logic [arbc_pkg::SMP_W-1:0] last_l,
  output logic [arbc_pkg::SMP_W-1:0] last_r
);
  timeunit 1ns;
  timeprecision 1ps;
  import arbc_pkg::*;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      out_ready <= 1'b0;
      taken <= 16'h0000;
    end else begin
      out_ready <= !stall;
      if (out_valid && out_ready) begin
        taken <= taken + 16'h0001;
        last_l <= out_data_l;
        last_r <= out_data_r;
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/arbc_top_tb.sv
// Self-checking bench for the record back end
`default_nettype none
module arbc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import arbc_pkg::*;
  logic clk_sys, sys_rst, clk_en, reg_wr, reg_rd, mod_sample, out_valid, out_ready, stall;
  logic [3:0] mclk_src_en;
  logic [THERM_W-1:0] mod_therm_l, mod_therm_r;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [5:0] pga_gain_l, pga_gain_r;
  logic [SMP_W-1:0] out_data_l, out_data_r, last_l, last_r;
  logic [2:0] out_route;
  logic [15:0] taken;
  logic [1:0] src;
  int num_errors, checks_done, n;
  logic [7:0] sel_t [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h05, 8'h08, 8'h0C};
  int per_t [8] = '{2, 4, 6, 6, 4, 4, 2, 2};
  arbc_top dut (.clk_sys, .sys_rst, .clk_en, .mclk_src_en, .mod_therm_l, .mod_therm_r, .mod_sample, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pga_gain_l, .pga_gain_r, .out_valid, .out_ready, .out_data_l,
    .out_data_r, .out_route);
  arbc_sink sink (.clk_sys, .sys_rst, .stall, .out_valid, .out_data_l, .out_data_r, .out_ready, .taken, .last_l,
    .last_r);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    mclk_src_en <= 4'h1 << src;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    check(reg_rdata, e);
  endtask
  task automatic wait_for(input int kind, input int lim, input logic [15:0] arg);
    for (n = 1; n <= lim; n++) begin
      @(posedge clk_sys);
      if (kind == 0 && mod_sample === 1'b1) return;
      if (kind == 1 && pga_gain_l !== arg[5:0]) return;
      if (kind == 2 && taken >= arg) return;
    end
    num_errors++;
    $display("unexpected at %0t: seen %h expected %h", $time, n, lim);
    print_verdict();
  endtask
  initial begin
    {sys_rst, clk_en} = 2'b11;
    {reg_wr, reg_rd, stall, src, reg_addr, reg_wdata} = '0;
    mod_therm_l = '0;
    mod_therm_r = '0;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdc(ADDR_ADC_CTRL, 8'h00);
    rdc(ADDR_CLK_SEL, 8'h00);
    wr(ADDR_CLK_SEL, 8'h0D);
    rdc(ADDR_CLK_SEL, 8'h0D);
    rdc(7'h7F, 8'h00);
    wr(ADDR_ADC_CTRL, 8'h0E);
    @(posedge clk_sys);
    check(out_route, 3'h7);
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      src <= sel_t[i][3:2];
      wr(ADDR_CLK_SEL, sel_t[i]);
      wr(ADDR_ADC_CTRL, {7'h00, i == 4});
      repeat (3) wait_for(0, 40, 16'h0000);
      check(n, per_t[i]);
    end
    $display("clock test done");
    src <= 2'h0;
    wr(ADDR_CLK_SEL, 8'h00);
    wr(ADDR_ADC_CTRL, 8'h00);
    mod_therm_l <= 31'h0000FFFF;
    wait_for(2, 20000, taken + 16'd40);
    check(last_l, 24'h000000);
    check(last_r, 24'hC00000);
    wr(ADDR_VOL_R, 8'h80);
    wait_for(2, 5000, taken + 16'd10);
    check(last_r, 24'hE00000);
    wr(ADDR_VOL_R, 8'h00);
    $display("data test done");
    stall <= 1'b1;
    repeat (1500) @(posedge clk_sys);
    check(out_valid, 1'b1);
    stall <= 1'b0;
    wait_for(2, 1000, taken + 16'd3);
    rdc(ADDR_STATUS, 8'h04);
    rdc(ADDR_STATUS, 8'h00);
    $display("stall test done");
    wr(ADDR_PGA_L, 8'h20);
    wr(ADDR_PGA_R, 8'h10);
    wr(ADDR_ALC2, 8'h00);
    wr(ADDR_ALC1, 8'h01);
    check({pga_gain_l, pga_gain_r}, 12'h810);
    wait_for(1, 1000, 16'h0020);
    check({pga_gain_l, pga_gain_r}, 12'h7CF);
    wait_for(1, 5000, 16'h001F);
    check({pga_gain_l, pga_gain_r}, 12'h78E);
    check(n > 3800 && n < 4400, 1'b1);
    wr(ADDR_ALC2, 8'hF0);
    wr(ADDR_ALC3, 8'h00);
    repeat (3) @(posedge clk_sys);
    check({pga_gain_l, pga_gain_r}, 12'h810);
    wr(ADDR_ALC1, 8'h03);
    wr(ADDR_ALC2, 8'h00);
    repeat (3000) @(posedge clk_sys);
    check({pga_gain_l, pga_gain_r}, 12'h810);
    mod_therm_l <= '0;
    wait_for(1, 8000, 16'h0020);
    check({pga_gain_l, pga_gain_r}, 12'h7CF);
    wr(ADDR_ALC1, 8'h00);
    repeat (3) @(posedge clk_sys);
    check({pga_gain_l, pga_gain_r}, 12'h810);
    wr(ADDR_PGA_L, 8'h3F);
    repeat (3) @(posedge clk_sys);
    check(pga_gain_l, 6'h30);
    $display("level control test done");
    print_verdict();
  end
endmodule
`default_nettype wire
